// [pkg/codec_regs_pkg.sv]
// constants, register map and carrier types of the codec control register bank
// assumes one clock (the link bit clock) and 16-bit register words
package codec_regs_pkg;

  localparam int          DATA_W   = 16;
  localparam int          INDEX_W  = 7;
  localparam int          SLOT_N   = 13;

  // register indices
  localparam logic [6:0]  IDX_CAPABILITY_AND_SOFT_RESET = 7'h00;
  localparam logic [6:0]  IDX_OUTPUT_VOLUME             = 7'h02;
  localparam logic [6:0]  IDX_MICROPHONE_BOOST          = 7'h0E;
  localparam logic [6:0]  IDX_RECORD_SOURCE_SELECT      = 7'h1A;
  localparam logic [6:0]  IDX_RECORD_GAIN               = 7'h1C;
  localparam logic [6:0]  IDX_FALLING_EDGE_IRQ_ENABLE   = 7'h60;
  localparam logic [6:0]  IDX_IRQ_STATUS_CLEAR          = 7'h62;
  localparam logic [6:0]  IDX_TOUCH_PANEL_CONTROL       = 7'h64;
  localparam logic [6:0]  IDX_CONVERTER_CONTROL         = 7'h66;
  localparam logic [6:0]  IDX_CONVERTER_RESULT          = 7'h68;
  localparam logic [6:0]  IDX_FEATURE_CONTROL_ONE       = 7'h6A;
  localparam logic [6:0]  IDX_FEATURE_CONTROL_TWO       = 7'h6C;
  localparam logic [6:0]  IDX_TEST_CONTROL              = 7'h6E;
  localparam logic [6:0]  IDX_CLIP_INTERRUPT_EXTRA      = 7'h70;
  localparam logic [6:0]  IDX_RESERVED_SLOT             = 7'h7A;
  localparam logic [6:0]  IDX_MAKER_CODE_HIGH           = 7'h7C;
  localparam logic [6:0]  IDX_MAKER_CODE_LOW            = 7'h7E;

  // storage slot numbers, one per stored register
  localparam int          SLOT_VOL    = 0;
  localparam int          SLOT_MIC    = 1;
  localparam int          SLOT_RSEL   = 2;
  localparam int          SLOT_RGAIN  = 3;
  localparam int          SLOT_NEGEN  = 4;
  localparam int          SLOT_ISTAT  = 5;
  localparam int          SLOT_TOUCH  = 6;
  localparam int          SLOT_ADCCTL = 7;
  localparam int          SLOT_ADCDAT = 8;
  localparam int          SLOT_FEAT1  = 9;
  localparam int          SLOT_FEAT2  = 10;
  localparam int          SLOT_TEST   = 11;
  localparam int          SLOT_EXTRA  = 12;

  localparam logic [SLOT_N-1:0][6:0] SLOT_INDEX = {
    IDX_CLIP_INTERRUPT_EXTRA, IDX_TEST_CONTROL, IDX_FEATURE_CONTROL_TWO,
    IDX_FEATURE_CONTROL_ONE, IDX_CONVERTER_RESULT, IDX_CONVERTER_CONTROL,
    IDX_TOUCH_PANEL_CONTROL, IDX_IRQ_STATUS_CLEAR, IDX_FALLING_EDGE_IRQ_ENABLE,
    IDX_RECORD_GAIN, IDX_RECORD_SOURCE_SELECT, IDX_MICROPHONE_BOOST,
    IDX_OUTPUT_VOLUME};

  // implemented bits of each slot; all other bits read zero
  localparam logic [SLOT_N-1:0][15:0] SLOT_MASK = {
    16'hE000, 16'h007F, 16'hFC37, 16'h7FFD, 16'h83FF, 16'h80BF,
    16'h3FFF, 16'hFBFF, 16'hFBFF, 16'h8F0F, 16'h0707, 16'h0040,
    16'hBF3F};

  // slots that software may write directly (IRQ status and clip slots are write-one-to-clear; the converter result slot is read-only)
  localparam logic [SLOT_N-1:0] SLOT_WRITABLE = 13'b0_1110_1101_1111;
  localparam logic [SLOT_N-1:0] SLOT_W1C      = 13'b1_0000_0010_0000;

  localparam logic [SLOT_N-1:0][15:0] SLOT_RESET = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000,
    16'h8000};

  localparam logic [15:0] CAPABILITY_VALUE = 16'h02A0;
  localparam logic [15:0] RESERVED_VALUE   = 16'h0000;
  localparam logic [15:0] RESULT_VALID_BIT = 16'h8000;
  localparam logic [2:0]  SOURCE_MIC_OR_COPY = 3'h0;
  localparam logic [2:0]  SOURCE_LINE_IN     = 3'h4;

  // arbitrary identification values
  localparam logic [15:0] MAKER_HIGH_DEFAULT = 16'h1234;
  localparam logic [15:0] MAKER_LOW_DEFAULT  = 16'h5678;

  typedef struct packed {
    logic       valid;
    logic       read;
    logic [6:0] index;
    logic [15:0] data;
  } link_cmd_type;

  typedef struct packed {
    logic        valid;
    logic [6:0]  index;
    logic [15:0] data;
  } link_status_type;

  typedef struct packed {
    logic       master_mute;
    logic [5:0] left_playback_attenuation;
    logic [5:0] right_playback_attenuation;
    logic       mic_boost;
    logic [2:0] left_record_source;
    logic [2:0] right_record_source;
    logic       right_copies_left;
    logic       record_mute;
    logic [3:0] left_record_gain;
    logic [3:0] right_record_gain;
  } audio_ctrl_type;

  typedef struct packed {
    logic [SLOT_N-1:0][15:0] regs;
    logic                    pend_valid;
    logic [6:0]              pend_index;
    logic [15:0]             pend_data;
    link_status_type         status;
  } bank_state_type;

endpackage

// [sim/codec_control_regs_monitor.sv]
// checker for the codec register bank, watching the top module ports only
// assumes frames every cycle while commands are issued
module codec_control_regs_monitor
  import codec_regs_pkg::*;
(
  input  wire logic            clk_i,         // link bit clock
  input  wire logic            resetn_i,      // reset, active low
  input  wire logic            frame_start_i, // frame pulse
  input  wire link_cmd_type    cmd_i,         // command slots
  input  wire link_status_type status_o,      // status slots
  input  wire audio_ctrl_type  audio_o        // decoded settings
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire rd_take = frame_start_i && cmd_i.valid && cmd_i.read;
  wire wr_take = frame_start_i && cmd_i.valid && !cmd_i.read;
  read_echo_a: assert property (rd_take ##1 frame_start_i |=> status_o.valid
    && status_o.index == $past(cmd_i.index, 2)) else $error("read not echoed");
  idle_frame_a: assert property (frame_start_i && !rd_take ##1 frame_start_i
    |=> !status_o.valid) else $error("status valid without read");
  odd_zero_a: assert property (rd_take && cmd_i.index[0] ##1 frame_start_i
    |=> status_o.data == 16'h0000) else $error("odd index data not zero");
  cap_value_a: assert property (rd_take && cmd_i.index == 7'h00 ##1 frame_start_i
    |=> status_o.data == 16'h02A0) else $error("capability value wrong");
  soft_reset_a: assert property (wr_take && cmd_i.index == 7'h00 |=> audio_o.master_mute
    && audio_o.record_mute && audio_o.left_playback_attenuation == 6'h00)
    else $error("soft reset missed");
  volume_a: assert property (wr_take && cmd_i.index == 7'h02 |=>
    audio_o.left_playback_attenuation == $past(cmd_i.data[13:8])
    && audio_o.right_playback_attenuation == $past(cmd_i.data[5:0]))
    else $error("attenuation not taken");
  gain_a: assert property (wr_take && cmd_i.index == 7'h1C |=>
    audio_o.left_record_gain == $past(cmd_i.data[11:8])
    && audio_o.record_mute == $past(cmd_i.data[15])) else $error("gain not taken");
  mic_a: assert property (wr_take && cmd_i.index == 7'h0E |=>
    audio_o.mic_boost == $past(cmd_i.data[6])) else $error("boost not taken");
  source_a: assert property (wr_take && cmd_i.index == 7'h1A |=>
    audio_o.left_record_source == $past(cmd_i.data[10:8])
    && audio_o.right_record_source == $past(cmd_i.data[2:0])) else $error("source wrong");
  copy_left_a: assert property (audio_o.right_record_source == 3'h0 |->
    audio_o.right_copies_left && audio_o.right_record_gain == audio_o.left_record_gain)
    else $error("right copy mode wrong");
endmodule

bind codec_control_regs codec_control_regs_monitor codec_control_regs_monitor_inst (
  .clk_i(clk_i), .resetn_i(resetn_i), .frame_start_i(frame_start_i),
  .cmd_i(cmd_i), .status_o(status_o), .audio_o(audio_o));

// [sim/codec_control_regs_tb.sv]
// self-checking bench for the codec register bank
// assumes the host model issues every command through whole link frames
module codec_control_regs_tb;
  import codec_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, run, conv_start, conv_done;
  logic [2:0] clip;
  logic frame_start;
  link_cmd_type cmd;
  link_status_type status;
  audio_ctrl_type audio;
  logic [15:0] q;
  logic [15:0] irq_en, touch, conv_ctl, feat1, feat2, test_ctl;
  int miscompares = 0, checked = 0, cycles = 0;
  localparam logic [6:0] WI[10] = '{7'h02, 7'h0E, 7'h1A, 7'h1C, 7'h60, 7'h64, 7'h66,
                                    7'h6A, 7'h6C, 7'h6E};
  localparam logic [15:0] WM[10] = '{16'hBF3F, 16'h0040, 16'h0707, 16'h8F0F, 16'hFBFF,
                                     16'h3FFF, 16'h80BF, 16'h7FFD, 16'hFC37, 16'h007F};
  codec_control_regs codec_control_regs_inst (.clk_i(clk), .resetn_i(resetn),
    .frame_start_i(frame_start), .cmd_i(cmd), .status_o(status), .audio_o(audio),
    .irq_enable_o(irq_en), .touch_control_o(touch), .converter_control_o(conv_ctl),
    .feature_one_o(feat1), .feature_two_o(feat2), .test_control_o(test_ctl),
    .irq_event_i(16'h0000), .clip_event_i(clip),
    .conv_start_i(conv_start), .conv_done_i(conv_done), .conv_value_i(10'h3FF));
  link_host_model link_host_model_inst (.clk_i(clk), .run_i(run),
    .frame_start_o(frame_start), .cmd_o(cmd), .status_i(status));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [6:0] i, input logic [15:0] d);
    link_host_model_inst.xfer(1'b0, i, d, q);
  endtask
  task automatic rd(input logic [6:0] i, input logic [15:0] e);
    link_host_model_inst.xfer(1'b1, i, 16'h0000, q);
    chk($sformatf("reg %h", i), e, q);
  endtask
  task automatic t_defaults;
    rd(7'h00, 16'h02A0);
    rd(7'h03, 16'h0000);
    rd(7'h7A, 16'h0000);
    rd(7'h7C, MAKER_HIGH_DEFAULT);
    for (int k = 0; k < 10; k++) rd(WI[k], k == 0 || k == 3 ? 16'h8000 : 16'h0000);
    $display("defaults done");
  endtask
  task automatic t_masks;
    for (int k = 0; k < 10; k++) wr(WI[k], 16'hFFFF);
    for (int k = 0; k < 10; k++) rd(WI[k], WM[k]);
    chk("irq enable out", 16'hFBFF, irq_en);
    chk("touch out", 16'h3FFF, touch);
    chk("converter control out", 16'h80BF, conv_ctl);
    chk("feature one out", 16'h7FFD, feat1);
    chk("feature two out", 16'hFC37, feat2);
    chk("test control out", 16'h007F, test_ctl);
    wr(7'h03, 16'h0000);
    rd(7'h02, 16'hBF3F);
    wr(7'h7C, 16'hFFFF);
    rd(7'h7C, MAKER_HIGH_DEFAULT);
    wr(7'h00, 16'hFFFF);
    rd(7'h00, 16'h02A0);
    rd(7'h02, 16'h8000);
    rd(7'h6E, 16'h0000);
    $display("masks and soft reset done");
  endtask
  task automatic t_copy;
    wr(7'h1C, 16'h0305);
    wr(7'h1A, 16'h0400);
    chk("copy gain", 16'h0003, {12'h000, audio.right_record_gain});
    wr(7'h1A, 16'h0404);
    chk("line gain", 16'h0005, {12'h000, audio.right_record_gain});
    $display("record source done");
  endtask
  task automatic t_adc;
    @(posedge clk) conv_done <= 1'b1;
    @(posedge clk) conv_done <= 1'b0;
    wr(7'h68, 16'h0000);
    rd(7'h68, 16'h83FF);
    @(posedge clk) conv_start <= 1'b1;
    clip <= 3'h7;
    @(posedge clk) conv_start <= 1'b0;
    clip <= 3'h0;
    rd(7'h68, 16'h03FF);
    rd(7'h70, 16'hE000);
    $display("converter done");
  endtask
  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      final_report();
    end
  end
  initial
  begin
    resetn = 1'b0;
    run = 1'b0;
    conv_start = 1'b0;
    conv_done = 1'b0;
    clip = 3'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    run <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_masks();
    t_copy();
    t_adc();
    final_report();
  end
endmodule

// [sim/link_host_model.sv]
// link host model: frame every cycle once running, one command per frame
// assumes the bank answers a read after the next frame start
module link_host_model
  import codec_regs_pkg::*;
(
  input  wire logic            clk_i,         // link bit clock
  input  wire logic            run_i,         // start framing
  output logic                 frame_start_o, // frame pulse
  output link_cmd_type         cmd_o,         // command slots
  input  wire link_status_type status_i       // status slots
);
  timeunit 1ns;
  timeprecision 1ps;
  initial frame_start_o = 1'b0;
  initial cmd_o = '0;
  always @(posedge clk_i) frame_start_o <= run_i;
  // command frame, then an idle frame carrying inverted leftovers, then take the answer
  task automatic xfer(input logic rd, input logic [6:0] idx, input logic [15:0] d,
                      output logic [15:0] q);
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b1, read: rd, index: idx, data: d};
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b0, read: ~rd, index: ~idx, data: ~d};
    @(posedge clk_i);
    #1 q = status_i.data;
  endtask
endmodule

// [src/codec_control_regs.sv]
// codec control and status register bank behind the link command/status slots
// assumes slot contents are delivered parallel, synchronous to clk_i
module codec_control_regs
  import codec_regs_pkg::*;
(
  input  wire logic            clk_i,              // link bit clock
  input  wire logic            resetn_i,           // asynchronous reset, active low
  input  wire logic            frame_start_i,      // one-cycle pulse at each frame start
  input  wire link_cmd_type    cmd_i,              // command slots, sampled at frame start
  output link_status_type      status_o,           // status slots for the current frame
  output audio_ctrl_type       audio_o,            // decoded audio settings
  output logic [15:0]          irq_enable_o,       // falling-edge interrupt enables
  output logic [15:0]          touch_control_o,    // touch panel control word
  output logic [15:0]          converter_control_o,// converter control word
  output logic [15:0]          feature_one_o,      // feature control word one
  output logic [15:0]          feature_two_o,      // feature control word two
  output logic [15:0]          test_control_o,     // test control word
  input  wire logic [15:0]     irq_event_i,        // interrupt events, one-cycle pulses
  input  wire logic [2:0]      clip_event_i,       // clip events: left, right, global
  input  wire logic            conv_start_i,       // converter sequence started
  input  wire logic            conv_done_i,        // converter result ready
  input  wire logic [9:0]      conv_value_i        // converter result
);

  logic [1:0]     rst_sync_q;
  logic           rst_n;
  bank_state_type state_q;
  bank_state_type state_d;
  logic [15:0]    read_value;
  logic           write_now;
  logic           soft_reset;
  logic [SLOT_N-1:0] hit;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n      = rst_sync_q[1];
  assign write_now  = frame_start_i && cmd_i.valid && !cmd_i.read;
  assign soft_reset = write_now && (cmd_i.index == IDX_CAPABILITY_AND_SOFT_RESET);

  // per-slot decode; an odd index matches no slot since all slot indices are even
  for (genvar s = 0; s < SLOT_N; s++)
  begin : g_decode
    assign hit[s] = (cmd_i.index == SLOT_INDEX[s]);
  end

  always_comb
  begin
    read_value = 16'h0000;
    for (int s = 0; s < SLOT_N; s++)
    begin
      if (hit[s])
        read_value = state_q.regs[s] & SLOT_MASK[s];
    end
    case (cmd_i.index)
      IDX_CAPABILITY_AND_SOFT_RESET: read_value = CAPABILITY_VALUE;
      IDX_RESERVED_SLOT:             read_value = RESERVED_VALUE;
      IDX_MAKER_CODE_HIGH:           read_value = MAKER_HIGH_DEFAULT;
      IDX_MAKER_CODE_LOW:            read_value = MAKER_LOW_DEFAULT;
      default:                       read_value = read_value;
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    if (frame_start_i)
    begin
      // answer last frame's read now, then take this frame's command
      state_d.status.valid = state_q.pend_valid;
      state_d.status.index = state_q.pend_index;
      state_d.status.data  = state_q.pend_data;
      state_d.pend_valid   = cmd_i.valid && cmd_i.read;
      state_d.pend_index   = cmd_i.index;
      state_d.pend_data    = read_value;
    end
    for (int s = 0; s < SLOT_N; s++)
    begin
      if (write_now && hit[s] && SLOT_WRITABLE[s])
        state_d.regs[s] = cmd_i.data & SLOT_MASK[s];
      if (write_now && hit[s] && SLOT_W1C[s])
        state_d.regs[s] = state_q.regs[s] & ~(cmd_i.data & SLOT_MASK[s]);
    end
    // hardware sets land after the clear so they win
    state_d.regs[SLOT_ISTAT] = state_d.regs[SLOT_ISTAT]
                             | (irq_event_i & SLOT_MASK[SLOT_ISTAT]);
    state_d.regs[SLOT_EXTRA] = state_d.regs[SLOT_EXTRA] | {clip_event_i, 13'h0000};
    if (conv_start_i)
      state_d.regs[SLOT_ADCDAT] = state_q.regs[SLOT_ADCDAT] & ~RESULT_VALID_BIT;
    if (conv_done_i)
      state_d.regs[SLOT_ADCDAT] = RESULT_VALID_BIT | {6'h00, conv_value_i};
    if (soft_reset)
      state_d.regs = SLOT_RESET;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q.regs       <= SLOT_RESET;
      state_q.pend_valid <= 1'b0;
      state_q.pend_index <= 7'h00;
      state_q.pend_data  <= 16'h0000;
      state_q.status     <= '0;
    end
    else
      state_q <= state_d;
  end

  always_comb
  begin
    status_o                            = state_q.status;
    audio_o.master_mute                 = state_q.regs[SLOT_VOL][15];
    audio_o.left_playback_attenuation   = state_q.regs[SLOT_VOL][13:8];
    audio_o.right_playback_attenuation  = state_q.regs[SLOT_VOL][5:0];
    audio_o.mic_boost                   = state_q.regs[SLOT_MIC][6];
    audio_o.left_record_source          = state_q.regs[SLOT_RSEL][10:8];
    audio_o.right_record_source         = state_q.regs[SLOT_RSEL][2:0];
    audio_o.right_copies_left           = (state_q.regs[SLOT_RSEL][2:0]
                                          == SOURCE_MIC_OR_COPY);
    audio_o.record_mute                 = state_q.regs[SLOT_RGAIN][15];
    audio_o.left_record_gain            = state_q.regs[SLOT_RGAIN][11:8];
    audio_o.right_record_gain           = audio_o.right_copies_left
                                          ? state_q.regs[SLOT_RGAIN][11:8]
                                          : state_q.regs[SLOT_RGAIN][3:0];
    irq_enable_o        = state_q.regs[SLOT_NEGEN];
    touch_control_o     = state_q.regs[SLOT_TOUCH];
    converter_control_o = state_q.regs[SLOT_ADCCTL];
    feature_one_o       = state_q.regs[SLOT_FEAT1];
    feature_two_o       = state_q.regs[SLOT_FEAT2];
    test_control_o      = state_q.regs[SLOT_TEST];
  end

endmodule
